// ==== ssc_pkg.sv ====
// package of constants and types for the sample clock selector
package ssc_pkg;
   localparam int SSC_DATA_W = 8;
   localparam int SSC_AXI_AW = 4;
   localparam int SSC_AXI_DW = 32;
   localparam int SSC_NUM_CLK = 4;
   // register byte offsets
   localparam logic [3:0] SSC_OFF_SEL_FIRST = 4'h0;
   localparam logic [3:0] SSC_OFF_SEL_SECOND = 4'h4;
   localparam logic [3:0] SSC_OFF_SEL_THIRD = 4'h8;
   localparam logic [3:0] SSC_OFF_STATUS = 4'hC;
   // selection register fields
   localparam int SSC_GATE_BIT = 6;
   localparam int SSC_STEP_BIT = 7;
   localparam logic [7:0] SSC_SEL_RESET = 8'h00;
   // status register fields
   localparam int SSC_STAT_SEL_LSB = 0;
   localparam int SSC_STAT_CONFLICT_BIT = 4;
   localparam int SSC_STAT_NONE_BIT = 5;
   // axi responses
   localparam logic [1:0] SSC_RESP_OKAY = 2'h0;
   localparam logic [1:0] SSC_RESP_SLVERR = 2'h2;
   // register index decode
   typedef enum {SSC_REG_FIRST, SSC_REG_SECOND, SSC_REG_THIRD, SSC_REG_STATUS, SSC_REG_NONE} ssc_reg_t;
   // one-hot gate selection, bit order a, b, c, step from lsb
   typedef struct packed {
      logic step;
      logic c;
      logic b;
      logic a;
   } ssc_select_t;
endpackage

// ==== ssc_clock_fanout.sv ====
// and-or clock gate and two-copy fan-out
`timescale 1ns/100ps
module ssc_clock_fanout (
   input wire logic [ssc_pkg::SSC_NUM_CLK-1:0] cand_clk,
   input wire ssc_pkg::ssc_select_t gate_sel,
   output logic copy_two,
   output logic copy_three
);
   import ssc_pkg::*;
   wire logic [SSC_NUM_CLK-1:0] sel_vec;
   wire logic [SSC_NUM_CLK-1:0] gated;
   wire logic master_clk;
   assign sel_vec = gate_sel;
   assign gated = cand_clk & sel_vec; // RULE_03
   assign master_clk = |gated; // RULE_03
   assign copy_two = master_clk; // RULE_06
   assign copy_three = master_clk; // RULE_06
endmodule // ssc_clock_fanout

// ==== ssc_sample_clock_selector.sv ====
// sample clock selector top: strobe-loaded selection registers, axi4-lite view, clock gating
// Function
// [RULE_01] A toggle on the first, second or third strobe loads the 8-bit data bus into that selection register.
// [RULE_02] Once a selection exists exactly one of the four gate bits is high and the others stay low.
// [RULE_03] Each candidate clock is ANDed with its gate bit and the results are ORed into one master clock.
// [RULE_04] The single-step gate bit is high only when the single-step source is the one chosen.
// [RULE_05] The controller picks the single-step source only for diagnostics and programming.
// [RULE_06] The master clock leaves as two identical copies, copy two and copy three.
// [RULE_07] No first copy of the master clock is driven or used.
// [RULE_08] The controller changes the selection only while acquisition is stopped.
//
// The register offsets and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/100ps
module ssc_sample_clock_selector (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [ssc_pkg::SSC_DATA_W-1:0] host_data,
   input wire logic select_reg_strobe_first,
   input wire logic select_reg_strobe_second,
   input wire logic select_reg_strobe_third,
   input wire logic [ssc_pkg::SSC_NUM_CLK-1:0] cand_clk,
   output ssc_pkg::ssc_select_t gate_select,
   output logic primary_sample_clock_copy_two,
   output logic primary_sample_clock_copy_three,
   input wire logic [ssc_pkg::SSC_AXI_AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [ssc_pkg::SSC_AXI_DW-1:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ssc_pkg::SSC_AXI_AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [ssc_pkg::SSC_AXI_DW-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   import ssc_pkg::*;

   function automatic ssc_reg_t decode_reg(input logic [SSC_AXI_AW-1:0] addr);
      case (addr)
         SSC_OFF_SEL_FIRST: decode_reg = SSC_REG_FIRST;
         SSC_OFF_SEL_SECOND: decode_reg = SSC_REG_SECOND;
         SSC_OFF_SEL_THIRD: decode_reg = SSC_REG_THIRD;
         SSC_OFF_STATUS: decode_reg = SSC_REG_STATUS;
         default: decode_reg = SSC_REG_NONE;
      endcase
   endfunction

   // strobe toggle detection
   logic [2:0] strobe_prev_reg;
   logic armed_reg;
   wire logic [2:0] strobe_now;
   wire logic [2:0] strobe_load;
   assign strobe_now = {select_reg_strobe_third, select_reg_strobe_second, select_reg_strobe_first};
   assign strobe_load = armed_reg ? (strobe_now ^ strobe_prev_reg) : 3'h0; // RULE_01

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         strobe_prev_reg <= 3'h0;
         armed_reg <= 1'b0;
      end else begin
         strobe_prev_reg <= strobe_now;
         armed_reg <= 1'b1;
      end
   end

   // axi write channel holding
   logic aw_hold_reg;
   logic [SSC_AXI_AW-1:0] aw_addr_reg;
   logic w_hold_reg;
   logic [SSC_DATA_W-1:0] w_data_reg;
   logic w_lane0_reg;
   logic bvalid_reg;
   logic [1:0] bresp_reg;
   wire logic do_write;
   ssc_reg_t wr_reg;
   wire logic wr_en;
   assign do_write = aw_hold_reg & w_hold_reg & ~bvalid_reg;
   assign wr_reg = decode_reg(aw_addr_reg);
   assign wr_en = do_write & w_lane0_reg;
   assign s_axi_awready = ~aw_hold_reg;
   assign s_axi_wready = ~w_hold_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_reg <= 1'b0;
         aw_addr_reg <= '0;
      end else if (s_axi_awvalid && !aw_hold_reg) begin
         aw_hold_reg <= 1'b1;
         aw_addr_reg <= s_axi_awaddr;
      end else if (do_write) begin
         aw_hold_reg <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_hold_reg <= 1'b0;
         w_data_reg <= '0;
         w_lane0_reg <= 1'b0;
      end else if (s_axi_wvalid && !w_hold_reg) begin
         w_hold_reg <= 1'b1;
         w_data_reg <= s_axi_wdata[SSC_DATA_W-1:0];
         w_lane0_reg <= s_axi_wstrb[0];
      end else if (do_write) begin
         w_hold_reg <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_reg <= 1'b0;
         bresp_reg <= SSC_RESP_OKAY;
      end else if (do_write) begin
         bvalid_reg <= 1'b1;
         bresp_reg <= (wr_reg == SSC_REG_NONE) ? SSC_RESP_SLVERR : SSC_RESP_OKAY;
      end else if (s_axi_bready) begin
         bvalid_reg <= 1'b0;
      end
   end

   // selection registers: strobe load wins over a software write in the same cycle
   logic [SSC_DATA_W-1:0] sel_reg [3];
   logic [SSC_DATA_W-1:0] sel_next [3];
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_sel
         assign sel_next[gi] = strobe_load[gi] ? host_data : // RULE_01
            ((wr_en && wr_reg == ssc_reg_t'(gi)) ? w_data_reg : sel_reg[gi]);
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               sel_reg[gi] <= SSC_SEL_RESET;
            end else begin
               sel_reg[gi] <= sel_next[gi];
            end
         end
      end
   endgenerate

   // gate bit decode and one-hot enforcement
   wire ssc_select_t raw_sel;
   wire ssc_select_t onehot_sel;
   wire logic conflict;
   assign raw_sel.a = sel_reg[0][SSC_GATE_BIT];
   assign raw_sel.b = sel_reg[1][SSC_GATE_BIT];
   assign raw_sel.c = sel_reg[2][SSC_GATE_BIT];
   assign raw_sel.step = sel_reg[0][SSC_STEP_BIT];
   assign onehot_sel.a = raw_sel.a; // RULE_02
   assign onehot_sel.b = raw_sel.b & ~raw_sel.a; // RULE_02
   assign onehot_sel.c = raw_sel.c & ~raw_sel.a & ~raw_sel.b; // RULE_02
   assign onehot_sel.step = raw_sel.step & ~raw_sel.a & ~raw_sel.b & ~raw_sel.c; // RULE_04
   assign conflict = ~$onehot0(raw_sel);

   ssc_select_t gate_sel_reg;
   logic conflict_reg;
   wire logic conflict_clear;
   assign conflict_clear = wr_en && wr_reg == SSC_REG_STATUS && w_data_reg[SSC_STAT_CONFLICT_BIT];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         gate_sel_reg <= '0;
         conflict_reg <= 1'b0;
      end else begin
         gate_sel_reg <= onehot_sel; // RULE_02
         conflict_reg <= conflict | (conflict_reg & ~conflict_clear);
      end
   end
   assign gate_select = gate_sel_reg;

   // only copies two and three exist; no first copy is produced
   ssc_clock_fanout u_fanout (
      .cand_clk(cand_clk),
      .gate_sel(gate_sel_reg),
      .copy_two(primary_sample_clock_copy_two), // RULE_07
      .copy_three(primary_sample_clock_copy_three)
   );

   // axi read channel
   logic rvalid_reg;
   logic [SSC_AXI_DW-1:0] rdata_reg;
   logic [1:0] rresp_reg;
   ssc_reg_t rd_reg;
   wire logic [SSC_AXI_DW-1:0] status_word;
   wire logic [SSC_AXI_DW-1:0] rd_word;
   assign rd_reg = decode_reg(s_axi_araddr);
   assign status_word = {26'h0000000, ~(|gate_sel_reg), conflict_reg, gate_sel_reg};
   assign rd_word = (rd_reg == SSC_REG_FIRST) ? {24'h000000, sel_reg[0]} :
      (rd_reg == SSC_REG_SECOND) ? {24'h000000, sel_reg[1]} :
      (rd_reg == SSC_REG_THIRD) ? {24'h000000, sel_reg[2]} :
      (rd_reg == SSC_REG_STATUS) ? status_word : 32'h00000000;
   assign s_axi_arready = ~rvalid_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_reg <= 1'b0;
         rdata_reg <= '0;
         rresp_reg <= SSC_RESP_OKAY;
      end else if (s_axi_arvalid && !rvalid_reg) begin
         rvalid_reg <= 1'b1;
         rdata_reg <= rd_word;
         rresp_reg <= (rd_reg == SSC_REG_NONE) ? SSC_RESP_SLVERR : SSC_RESP_OKAY;
      end else if (s_axi_rready) begin
         rvalid_reg <= 1'b0;
      end
   end

   // checks
   property p_strobe_load; // RULE_01
      @(posedge aclk) disable iff (!aresetn)
      (armed_reg && (select_reg_strobe_first != strobe_prev_reg[0])) |=> (sel_reg[0] == $past(host_data));
   endproperty
   a_strobe_load: assert property (p_strobe_load) else $error("first selection register missed strobe load"); // RULE_01

   property p_onehot; // RULE_02
      @(posedge aclk) disable iff (!aresetn)
      (|raw_sel) |=> $onehot(gate_sel_reg);
   endproperty
   a_onehot: assert property (p_onehot) else $error("gate select not one-hot after a selection"); // RULE_02

   property p_and_or; // RULE_03
      @(posedge aclk) disable iff (!aresetn)
      primary_sample_clock_copy_two == (|(cand_clk & gate_sel_reg));
   endproperty
   a_and_or: assert property (p_and_or) else $error("master clock differs from gated candidates"); // RULE_03

   property p_step_only; // RULE_04
      @(posedge aclk) disable iff (!aresetn)
      ##1 (gate_sel_reg.step == ($past(raw_sel) == 4'h8));
   endproperty
   a_step_only: assert property (p_step_only) else $error("single-step gate bit wrongly set or cleared"); // RULE_04

   property p_copies; // RULE_06
      @(posedge aclk) disable iff (!aresetn)
      primary_sample_clock_copy_two == primary_sample_clock_copy_three;
   endproperty
   a_copies: assert property (p_copies) else $error("clock copies differ"); // RULE_06

   property p_quiet; // RULE_07
      @(posedge aclk) disable iff (!aresetn)
      (raw_sel == 4'h0) |=> !primary_sample_clock_copy_two && !primary_sample_clock_copy_three;
   endproperty
   a_quiet: assert property (p_quiet) else $error("clock copy active with no selection"); // RULE_07
endmodule // ssc_sample_clock_selector

// ==== ssc_host_model.sv ====
// host controller model: drives the selection data bus and latch strobes
`timescale 1ns/100ps
module ssc_host_model (
   input wire logic aclk,
   output logic [7:0] host_data,
   output logic [2:0] strobe
);
   initial begin
      host_data = 8'hFF;
      strobe = 3'h0;
   end
   // one toggle per load, data bus inverted on the clock after the toggle
   task automatic load(input int idx, input logic [7:0] val);
      @(posedge aclk);
      host_data <= val;
      strobe[idx] <= ~strobe[idx];
      @(posedge aclk);
      host_data <= ~val;
   endtask
endmodule // ssc_host_model

// ==== ssc_sample_clock_selector_bench.sv ====
// self-checking bench for the sample clock selector
`timescale 1ns/100ps
module ssc_sample_clock_selector_bench;
   import ssc_pkg::*;
   logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic [3:0] awaddr, araddr, cand_clk, wstrb;
   logic [31:0] wdata, rdata;
   logic [1:0] bresp, rresp;
   logic [7:0] host_data;
   logic [2:0] strobe;
   ssc_select_t gate_select;
   logic copy_two, copy_three;
   int err_total, checks_done;
   ssc_host_model host_u (.aclk(aclk), .host_data(host_data), .strobe(strobe));
   ssc_sample_clock_selector dut_u (.aclk(aclk), .aresetn(aresetn), .host_data(host_data),
      .select_reg_strobe_first(strobe[0]), .select_reg_strobe_second(strobe[1]),
      .select_reg_strobe_third(strobe[2]), .cand_clk(cand_clk), .gate_select(gate_select),
      .primary_sample_clock_copy_two(copy_two), .primary_sample_clock_copy_three(copy_three),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready));
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   // distinct candidate clock patterns
   always @(posedge aclk) begin
      if (!aresetn) begin
         cand_clk <= 4'h0;
      end else begin
         cand_clk <= cand_clk + 4'h1;
      end
   end
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish();
      if (err_total == 0 && checks_done > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      bready <= 1'b0;
      cmp({30'h0, bresp}, {30'h0, er});
   endtask
   task automatic axi_rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      rready <= 1'b0;
      cmp(rdata, ed);
      cmp({30'h0, rresp}, {30'h0, er});
   endtask
   // gate bits and both copies against the expected one-hot
   task automatic chk_sel(input logic [3:0] e);
      repeat (2) @(posedge aclk);
      repeat (4) begin
         @(posedge aclk);
         #2;
         cmp({28'h0, gate_select}, {28'h0, e});
         cmp({31'h0, copy_two}, {31'h0, |(cand_clk & e)});
         cmp({31'h0, copy_three}, {31'h0, |(cand_clk & e)});
      end
   endtask
   initial begin
      repeat (5000) @(posedge aclk);
      err_total++;
      tally_and_finish();
   end
   initial begin
      err_total = 0;
      checks_done = 0;
      aresetn = 1'b0;
      wstrb = 4'hF;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      awaddr = 4'h0;
      araddr = 4'h0;
      wdata = 32'h0;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      axi_rd(SSC_OFF_STATUS, 32'h20, SSC_RESP_OKAY);
      chk_sel(4'h0);
      host_u.load(0, 8'h40);
      chk_sel(4'h1);
      host_u.load(0, 8'h80);
      chk_sel(4'h8);
      host_u.load(0, 8'hC0);
      chk_sel(4'h1);
      host_u.load(0, 8'h00);
      chk_sel(4'h0);
      host_u.load(1, 8'h40);
      chk_sel(4'h2);
      host_u.load(2, 8'h40);
      chk_sel(4'h2);
      axi_rd(SSC_OFF_STATUS, 32'h12, SSC_RESP_OKAY);
      host_u.load(1, 8'h00);
      chk_sel(4'h4);
      axi_wr(SSC_OFF_STATUS, 32'h10, SSC_RESP_OKAY);
      axi_rd(SSC_OFF_STATUS, 32'h04, SSC_RESP_OKAY);
      axi_wr(SSC_OFF_SEL_SECOND, 32'h12345640, SSC_RESP_OKAY);
      axi_rd(SSC_OFF_SEL_SECOND, 32'h40, SSC_RESP_OKAY);
      // a write without byte lane zero leaves the register alone
      wstrb <= 4'hE;
      axi_wr(SSC_OFF_SEL_SECOND, 32'h00, SSC_RESP_OKAY);
      wstrb <= 4'hF;
      axi_rd(SSC_OFF_SEL_SECOND, 32'h40, SSC_RESP_OKAY);
      chk_sel(4'h2);
      axi_wr(4'h2, 32'h40, SSC_RESP_SLVERR);
      axi_rd(4'h2, 32'h0, SSC_RESP_SLVERR);
      tally_and_finish();
   end
endmodule // ssc_sample_clock_selector_bench
